/* core/asr_top.sv */
// Serial audio output with buffer-driven transfer rate trimming
// Functional notes
// - Word period set by delay field, 341/342/343.
// - Wrap off stops after last word, flag set.
// - Circular sample buffer of 800 bytes holds at most 799.
// - Limits about 400 bytes from mid-point.
// - Master drives serial clock and data out.
// - Left and right selects alternate per word.
// - Fast above upper, slow below lower, nominal mid.
// - Slow rate selected after reset.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module asr_top (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output var  logic [31:0] rdata_o,
	output var  logic        irq_o,
	output var  logic        sck_o,
	output var  logic        mosi_o,
	output var  logic        left_sel_n_o,
	output var  logic        right_sel_n_o
);
	logic [8:0]  delay_field, next_delay_field;
	logic        port_en, next_port_en;
	logic        wrap_en, next_wrap_en;
	logic [2:0]  status, next_status;
	logic [2:0]  mask, next_mask;
	logic [9:0]  wp, next_wp;
	logic [9:0]  rp, next_rp;
	asr_pkg::asr_rate_e  rate, next_rate;
	asr_pkg::asr_state_e state, next_state;
	logic [8:0]  delay_run, next_delay_run;
	logic [8:0]  per_cnt, next_per_cnt;
	logic [2:0]  half_cnt, next_half_cnt;
	logic [4:0]  bit_cnt, next_bit_cnt;
	logic [15:0] shreg, next_shreg;
	logic [15:0] last_word, next_last_word;
	logic [7:0]  hi_byte, next_hi_byte;
	logic        ch, next_ch;
	logic [3:0]  q_idx, next_q_idx;
	logic        next_sck, next_mosi, next_lsel_n, next_rsel_n;
	logic [31:0] next_rdata;
	logic        next_irq;
	logic [10:0] occ_wide;
	logic [9:0]  occ;
	logic [8:0]  rec_delay;
	logic        mem_wr, mem_rd;
	logic [7:0]  mem_rdata;
	logic [2:0]  ev_set;
	logic [2:0]  ovf_set;
	logic        stop_ev;

	asr_sample_ram u_ram (
		.clk_i     (clk_i),
		.wr_en_i   (mem_wr),
		.wr_addr_i (wp),
		.wr_data_i (wdata_i[7:0]),
		.rd_en_i   (mem_rd),
		.rd_addr_i (rp),
		.rd_data_o (mem_rdata)
	);

	// Occupancy modulo buffer size and the period it recommends
	always_comb begin
		if (wp >= rp) begin
			occ_wide = {1'b0, wp} - {1'b0, rp};
		end else begin
			occ_wide = {1'b0, wp} + {1'b0, asr_pkg::BUF_BYTES} - {1'b0, rp};
		end
		occ = occ_wide[9:0];
		case (rate)
			asr_pkg::RATE_FAST: rec_delay = asr_pkg::DLY_FAST;
			asr_pkg::RATE_NORM: rec_delay = asr_pkg::DLY_NOMINAL;
			default:            rec_delay = asr_pkg::DLY_SLOW;
		endcase
	end

	// Rate choice with hysteresis around the mid-point
	always_comb begin
		next_rate = rate;
		if (occ > asr_pkg::LIMIT_HI) begin
			next_rate = asr_pkg::RATE_FAST;
		end else if (occ < asr_pkg::LIMIT_LO) begin
			next_rate = asr_pkg::RATE_SLOW;
		end else if ((rate == asr_pkg::RATE_FAST && occ <= asr_pkg::LIMIT_MID) ||
			(rate == asr_pkg::RATE_SLOW && occ >= asr_pkg::LIMIT_MID)) begin
			next_rate = asr_pkg::RATE_NORM;
		end
	end

	// Transfer engine: fetch, shift out, pad to the word period
	always_comb begin
		next_state     = state;
		next_delay_run = delay_run;
		next_per_cnt   = per_cnt + 9'h001;
		next_half_cnt  = half_cnt;
		next_bit_cnt   = bit_cnt;
		next_shreg     = shreg;
		next_last_word = last_word;
		next_hi_byte   = hi_byte;
		next_ch        = ch;
		next_q_idx     = q_idx;
		next_sck       = sck_o;
		next_mosi      = mosi_o;
		next_lsel_n    = left_sel_n_o;
		next_rsel_n    = right_sel_n_o;
		next_rp        = rp;
		mem_rd         = 1'b0;
		stop_ev        = 1'b0;
		ev_set         = 3'h0;
		case (state)
			asr_pkg::ST_IDLE: begin
				next_per_cnt = 9'h000;
				next_sck     = 1'b0;
				next_mosi    = 1'b0;
				next_lsel_n  = 1'b1;
				next_rsel_n  = 1'b1;
				if (port_en) begin
					next_delay_run = delay_field;
					next_q_idx     = 4'h0;
					next_ch        = 1'b0;
					next_state     = asr_pkg::ST_FHI;
				end
			end
			asr_pkg::ST_FHI: begin
				next_lsel_n = ch;
				next_rsel_n = ~ch;
				if (occ >= 10'h002) begin
					mem_rd     = 1'b1;
					next_rp    = (rp == asr_pkg::BUF_BYTES - 10'h001) ? 10'h000 : rp + 10'h001;
					next_state = asr_pkg::ST_FLO;
				end else begin
					// Starved buffer repeats the previous word
					ev_set[asr_pkg::ST_UNDERRUN] = 1'b1;
					next_shreg    = last_word;
					next_mosi     = last_word[15];
					next_half_cnt = 3'h0;
					next_bit_cnt  = 5'h00;
					next_state    = asr_pkg::ST_SHIFT;
				end
			end
			asr_pkg::ST_FLO: begin
				next_hi_byte = mem_rdata;
				mem_rd       = 1'b1;
				next_rp      = (rp == asr_pkg::BUF_BYTES - 10'h001) ? 10'h000 : rp + 10'h001;
				next_state   = asr_pkg::ST_LOAD;
			end
			asr_pkg::ST_LOAD: begin
				next_shreg     = {hi_byte, mem_rdata};
				next_last_word = {hi_byte, mem_rdata};
				next_mosi      = hi_byte[7];
				next_half_cnt  = 3'h0;
				next_bit_cnt   = 5'h00;
				next_state     = asr_pkg::ST_SHIFT;
			end
			asr_pkg::ST_SHIFT: begin
				next_half_cnt = half_cnt + 3'h1;
				if (half_cnt == asr_pkg::SCK_HALF_LAST) begin
					next_half_cnt = 3'h0;
					if (!sck_o) begin
						next_sck = 1'b1;
					end else begin
						next_sck     = 1'b0;
						next_bit_cnt = bit_cnt + 5'h01;
						next_shreg   = {shreg[14:0], 1'b0};
						next_mosi    = shreg[14];
						if (bit_cnt == asr_pkg::WORD_LAST) begin
							// Select release latches the word
							next_lsel_n = 1'b1;
							next_rsel_n = 1'b1;
							next_state  = asr_pkg::ST_GAP;
						end
					end
				end
			end
			asr_pkg::ST_GAP: begin
				if (per_cnt == delay_run - 9'h001) begin
					next_q_idx   = q_idx + 4'h1;
					next_ch      = ~ch;
					next_per_cnt = 9'h000;
					if (!wrap_en && q_idx == asr_pkg::QUEUE_LAST) begin
						stop_ev    = 1'b1;
						ev_set[asr_pkg::ST_FINISHED] = 1'b1;
						next_state = asr_pkg::ST_IDLE;
					end else begin
						next_state = asr_pkg::ST_FHI;
					end
				end
			end
			default: begin
				next_state = asr_pkg::ST_IDLE;
			end
		endcase
	end

	// Register slave, buffer push and interrupt status
	always_comb begin
		next_delay_field = delay_field;
		next_port_en     = port_en;
		next_wrap_en     = wrap_en;
		next_mask        = mask;
		next_wp          = wp;
		mem_wr           = 1'b0;
		next_rdata       = 32'h0000_0000;
		next_status      = status;
		ovf_set          = 3'h0; // Overflow event has its own vector, one driver each
		if (stop_ev) begin
			next_port_en = 1'b0;
		end
		if (wr_i) begin
			case (addr_i)
				asr_pkg::OFF_CTRL1: begin
					// Ignored while the port runs
					if (state == asr_pkg::ST_IDLE) begin
						next_delay_field = wdata_i[8:0];
						next_port_en     = wdata_i[asr_pkg::CTRL1_EN_BIT];
					end
				end
				asr_pkg::OFF_CTRL2: next_wrap_en = wdata_i[asr_pkg::CTRL2_WRAP_BIT];
				asr_pkg::OFF_STATUS: next_status = status & ~wdata_i[2:0];
				asr_pkg::OFF_MASK: next_mask = wdata_i[2:0];
				asr_pkg::OFF_DATA: begin
					if (occ == asr_pkg::BUF_BYTES - 10'h001) begin
						ovf_set[asr_pkg::ST_OVERFLOW] = 1'b1;
					end else begin
						mem_wr  = 1'b1;
						next_wp = (wp == asr_pkg::BUF_BYTES - 10'h001) ? 10'h000 : wp + 10'h001;
					end
				end
				default: next_status = status;
			endcase
		end
		next_status = next_status | ev_set | ovf_set; // Set wins over clear
		if (rd_i) begin
			case (addr_i)
				asr_pkg::OFF_CTRL1: next_rdata = {16'h0000, port_en, 6'h00, delay_field};
				asr_pkg::OFF_CTRL2: next_rdata = {31'h0, wrap_en};
				asr_pkg::OFF_STATUS: next_rdata = {29'h0, status};
				asr_pkg::OFF_MASK: next_rdata = {29'h0, mask};
				asr_pkg::OFF_LEVEL: next_rdata = {q_idx, 3'h0, rec_delay, 6'h00, occ};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		next_irq = |(next_status & next_mask);
	end

	// State registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			delay_field   <= asr_pkg::DLY_SLOW;
			port_en       <= 1'b0;
			wrap_en       <= asr_pkg::WRAP_RESET;
			status        <= 3'h0;
			mask          <= asr_pkg::MASK_RESET;
			wp            <= 10'h000;
			rp            <= 10'h000;
			rate          <= asr_pkg::RATE_SLOW;
			state         <= asr_pkg::ST_IDLE;
			delay_run     <= asr_pkg::DLY_SLOW;
			per_cnt       <= 9'h000;
			half_cnt      <= 3'h0;
			bit_cnt       <= 5'h00;
			shreg         <= 16'h0000;
			last_word     <= 16'h0000;
			hi_byte       <= 8'h00;
			ch            <= 1'b0;
			q_idx         <= 4'h0;
			sck_o         <= 1'b0;
			mosi_o        <= 1'b0;
			left_sel_n_o  <= 1'b1;
			right_sel_n_o <= 1'b1;
			rdata_o       <= 32'h0000_0000;
			irq_o         <= 1'b0;
		end else begin
			delay_field   <= next_delay_field;
			port_en       <= next_port_en;
			wrap_en       <= next_wrap_en;
			status        <= next_status;
			mask          <= next_mask;
			wp            <= next_wp;
			rp            <= next_rp;
			rate          <= next_rate;
			state         <= next_state;
			delay_run     <= next_delay_run;
			per_cnt       <= next_per_cnt;
			half_cnt      <= next_half_cnt;
			bit_cnt       <= next_bit_cnt;
			shreg         <= next_shreg;
			last_word     <= next_last_word;
			hi_byte       <= next_hi_byte;
			ch            <= next_ch;
			q_idx         <= next_q_idx;
			sck_o         <= next_sck;
			mosi_o        <= next_mosi;
			left_sel_n_o  <= next_lsel_n;
			right_sel_n_o <= next_rsel_n;
			rdata_o       <= next_rdata;
			irq_o         <= next_irq;
		end
	end

	// Checks on the rate, framing and stop behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_word_period: assert property ((state == asr_pkg::ST_FHI && $past(state) == asr_pkg::ST_GAP) |-> $past(per_cnt) == delay_run - 9'h001) else $error("word period differs from delay");
	a_nominal_value: assert property ((rate == asr_pkg::RATE_NORM) |-> rec_delay == 9'h156) else $error("nominal period wrong");
	a_fast_select: assert property ((occ > 10'h318) |=> rate == asr_pkg::RATE_FAST) else $error("fast rate not chosen");
	a_mid_normal: assert property ((rate == asr_pkg::RATE_SLOW && occ >= 10'h190 && occ >= 10'h008 && occ <= 10'h318) |=> rate == asr_pkg::RATE_NORM) else $error("nominal not chosen at mid");
	a_reset_slow: assert property ($fell(sys_rst_i) |-> rate == asr_pkg::RATE_SLOW) else $error("not slow after reset");
	a_occ_bound: assert property (occ < 10'h320) else $error("occupancy beyond buffer");
	a_stop_flag: assert property ((state == asr_pkg::ST_GAP && !wrap_en && q_idx == 4'hF && per_cnt == delay_run - 9'h001) |=> (status[0] && !port_en && state == asr_pkg::ST_IDLE)) else $error("stop did not flag");
	a_sel_exclusive: assert property (!(!left_sel_n_o && !right_sel_n_o)) else $error("both selects active");
	a_sel_alternate: assert property ((!left_sel_n_o && $past(left_sel_n_o) && $past(state) == asr_pkg::ST_FHI) |-> !ch) else $error("left select on wrong word");
	a_sck_idle: assert property ((state == asr_pkg::ST_IDLE) |=> !sck_o) else $error("serial clock active while idle");
	a_occ_diff: assert property (($past(wp) == wp && $past(rp) == rp) |-> $stable(occ)) else $error("occupancy unstable");

	c_fast_rate: cover property (rate == asr_pkg::RATE_FAST);
	c_slow_to_norm: cover property (rate == asr_pkg::RATE_SLOW ##1 rate == asr_pkg::RATE_NORM);
	c_stop_restart: cover property (stop_ev ##[1:60] state == asr_pkg::ST_FHI);
endmodule
`default_nettype wire

/* core/asr_pkg.sv */
// Shared constants and types for the audio serial rate-adjust block
package asr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL1  = 8'h00;
	localparam logic [7:0] OFF_CTRL2  = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_MASK   = 8'h0C;
	localparam logic [7:0] OFF_DATA   = 8'h10;
	localparam logic [7:0] OFF_LEVEL  = 8'h14;
	// Field positions
	localparam int CTRL1_EN_BIT   = 15;
	localparam int CTRL2_WRAP_BIT = 0;
	localparam int ST_FINISHED    = 0;
	localparam int ST_OVERFLOW    = 1;
	localparam int ST_UNDERRUN    = 2;
	localparam int ST_W           = 3;
	localparam int LEVEL_DLY_LSB  = 16;
	localparam int LEVEL_IDX_LSB  = 28;
	// Transfer period in system clocks
	localparam int DLY_W = 9;
	localparam logic [8:0] DLY_FAST    = 9'h155;
	localparam logic [8:0] DLY_NOMINAL = 9'h156;
	localparam logic [8:0] DLY_SLOW    = 9'h157;
	// Circular buffer geometry and occupancy thresholds
	localparam int PTR_W = 10;
	localparam logic [9:0] BUF_BYTES = 10'h320;
	localparam logic [9:0] LIMIT_LO  = 10'h008;
	localparam logic [9:0] LIMIT_MID = 10'h190;
	localparam logic [9:0] LIMIT_HI  = 10'h318;
	// Serial word and queue shape
	localparam logic [4:0] WORD_LAST  = 5'h0F;
	localparam logic [3:0] QUEUE_LAST = 4'hF;
	// Serial clock half period
	localparam int CLK_MHZ     = 40;
	localparam int SCK_HALF_NS = 100;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam logic [2:0] SCK_HALF_LAST = 3'(SCK_HALF_CYC - 1);
	// Reset values
	localparam logic       WRAP_RESET = 1'b1;
	localparam logic [2:0] MASK_RESET = 3'h0;
	// Rate choice
	typedef enum logic [2:0] {
		RATE_SLOW = 3'b001,
		RATE_NORM = 3'b010,
		RATE_FAST = 3'b100
	} asr_rate_e;
	// Transfer engine states
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_FHI   = 6'b000010,
		ST_FLO   = 6'b000100,
		ST_LOAD  = 6'b001000,
		ST_SHIFT = 6'b010000,
		ST_GAP   = 6'b100000
	} asr_state_e;
endpackage

/* core/asr_sample_ram.sv */
// Byte-wide sample memory for the circular buffer
`timescale 1ns/10ps
`default_nettype none
module asr_sample_ram (
	input  wire logic       clk_i,
	input  wire logic       wr_en_i,
	input  wire logic [9:0] wr_addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       rd_en_i,
	input  wire logic [9:0] rd_addr_i,
	output var  logic [7:0] rd_data_o
);
	logic [7:0] mem [0:799];

	// Write port and registered read port
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		if (rd_en_i) begin
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule
`default_nettype wire

/* tb/asr_dac_model.sv */
// Behavioural model of the two-channel serial audio converter
`timescale 1ns/10ps
`default_nettype none
module asr_dac_model (
	input  wire logic        sck_i,
	input  wire logic        data_i,
	input  wire logic        left_latch_n_i,
	input  wire logic        right_latch_n_i,
	output var  logic [15:0] word_o,
	output var  logic        chan_o,
	output var  int          bits_o,
	output var  int          count_o
);
	logic [15:0] shreg;
	logic        chan_q;
	int          nbits;

	// Quiet converter at time zero
	initial begin
		shreg = 16'h0000;
		chan_q = 1'b0;
		nbits = 0;
		word_o = 16'h0000;
		chan_o = 1'b0;
		bits_o = 0;
		count_o = 0;
	end

	// Shift in on the rising serial clock while a channel is selected
	always @(posedge sck_i) begin
		if (left_latch_n_i === 1'b0 || right_latch_n_i === 1'b0) begin
			shreg = {shreg[14:0], data_i};
			chan_q = (right_latch_n_i === 1'b0);
			nbits = nbits + 1;
		end
	end

	// Latch the word into the channel whose select rises
	always @(posedge left_latch_n_i or posedge right_latch_n_i) begin
		if (nbits != 0) begin
			word_o = shreg;
			chan_o = chan_q;
			bits_o = nbits;
			nbits = 0;
			count_o = count_o + 1;
		end
	end
endmodule
`default_nettype wire

/* tb/asr_top_test.sv */
// Self-checking bench for the audio serial rate-adjust block
`timescale 1ns/10ps
`default_nettype none
module asr_top_test;
	logic        clk_i;
	logic        sys_rst_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic        irq_o;
	logic        sck_o;
	logic        mosi_o;
	logic        left_sel_n_o;
	logic        right_sel_n_o;
	logic [15:0] dac_word;
	logic        dac_chan;
	int          dac_bits;
	int          dac_count;
	int          errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          occ = 0;
	logic [8:0]  rate_dly;
	logic [31:0] lfsr;
	logic [31:0] v;
	logic        exp_chan;
	logic [7:0]  bytes_q[$];

	asr_top asr_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.sck_o(sck_o), .mosi_o(mosi_o), .left_sel_n_o(left_sel_n_o),
		.right_sel_n_o(right_sel_n_o));
	asr_dac_model asr_dac_model_inst (.sck_i(sck_o), .data_i(mosi_o),
		.left_latch_n_i(left_sel_n_o), .right_latch_n_i(right_sel_n_o),
		.word_o(dac_word), .chan_o(dac_chan), .bits_o(dac_bits), .count_o(dac_count));

	// 40 MHz clock and a cycle counter
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cyc <= cyc + 1;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected recommended delay after an occupancy change
	function automatic logic [8:0] next_dly(input logic [8:0] d, input int n);
		if (n > 792) return 9'h155;
		if (n < 8) return 9'h157;
		if ((d == 9'h155 && n <= 400) || (d == 9'h157 && n >= 400)) return 9'h156;
		return d;
	endfunction

	task automatic test_done;
		if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk_i);
		#1;
		chk({31'h0, irq_o}, {31'h0, e});
	endtask

	// Occupancy and recommended delay, word index masked off
	task automatic lvl;
		logic [31:0] r;
		rd(asr_pkg::OFF_LEVEL, r);
		chk(r & 32'h01FF03FF, {7'h00, rate_dly, 6'h00, 10'(occ)});
	endtask

	// Push one random byte while the port is stopped
	task automatic push;
		lfsr = lfsr_next(lfsr);
		wr(asr_pkg::OFF_DATA, lfsr);
		if (occ < 799) begin
			bytes_q.push_back(lfsr[7:0]);
			occ++;
			rate_dly = next_dly(rate_dly, occ);
		end
		lvl();
	endtask

	task automatic sel_fall(input logic right, output int at);
		logic prev;
		logic cur;
		prev = 1'b1;
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk_i);
			#1;
			cur = right ? right_sel_n_o : left_sel_n_o;
			if (prev === 1'b1 && cur === 1'b0) break;
			prev = cur;
		end
		at = cyc;
	endtask

	// One queue pass at a given delay, stopped through wrap disable
	task automatic run(input logic [8:0] d);
		int ta;
		int tb;
		int c0;
		logic [31:0] r;
		c0 = dac_count;
		exp_chan = 1'b0;
		wr(asr_pkg::OFF_CTRL2, 32'h1);
		wr(asr_pkg::OFF_CTRL1, {16'h0000, 1'b1, 6'h00, d});
		sel_fall(1'b0, ta);
		sel_fall(1'b1, tb);
		chk(32'(tb - ta), {23'h0, d});
		wr(asr_pkg::OFF_CTRL1, 32'h0000015A);
		rd(asr_pkg::OFF_CTRL1, r);
		chk(r, {16'h0000, 1'b1, 6'h00, d});
		wr(asr_pkg::OFF_CTRL2, 32'h0);
		for (int i = 0; i < 20000; i++) begin
			rd(asr_pkg::OFF_STATUS, r);
			if (r[0] === 1'b1) break;
		end
		chk(r & 32'h1, 32'h1);
		rd(asr_pkg::OFF_CTRL1, r);
		chk(r, {23'h0, d});
		chk(32'(dac_count - c0), 32'd16);
	endtask

	// Each latched converter word against the bytes pushed earlier
	always @(dac_count) begin
		if (dac_count > 0) begin
			chk({16'h0000, dac_word}, {16'h0000, bytes_q[0], bytes_q[1]});
			chk({31'h0, dac_chan}, {31'h0, exp_chan});
			chk(dac_bits, 32'd16);
			void'(bytes_q.pop_front());
			void'(bytes_q.pop_front());
			exp_chan = ~exp_chan;
			occ = occ - 2;
			rate_dly = next_dly(rate_dly, occ);
		end
	end

	// Watchdog
	initial begin
		repeat (90000) @(posedge clk_i);
		errors++;
		test_done();
	end

	// Main sequence
	initial begin
		sys_rst_i = 1'b1;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		lfsr = 32'h0bbf269c;
		rate_dly = 9'h157;
		exp_chan = 1'b0;
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(asr_pkg::OFF_CTRL1, v);
		chk(v, 32'h00000157);
		rd(asr_pkg::OFF_CTRL2, v);
		chk(v, 32'h00000001);
		rd(asr_pkg::OFF_STATUS, v);
		chk(v, 32'h0);
		rd(asr_pkg::OFF_MASK, v);
		chk(v, 32'h0);
		rd(8'h40, v);
		chk(v, 32'h0);
		lvl();
		irq_is(1'b0);
		repeat (64) push();
		run(9'h156);
		lvl();
		irq_is(1'b0);
		wr(asr_pkg::OFF_MASK, 32'h1);
		irq_is(1'b1);
		wr(asr_pkg::OFF_STATUS, 32'h1);
		irq_is(1'b0);
		run(9'h155);
		lvl();
		wr(asr_pkg::OFF_STATUS, 32'h1);
		repeat (800) push();
		rd(asr_pkg::OFF_STATUS, v);
		chk(v, 32'h00000002);
		wr(asr_pkg::OFF_MASK, 32'h2);
		irq_is(1'b1);
		wr(asr_pkg::OFF_STATUS, 32'h2);
		irq_is(1'b0);
		test_done();
	end
endmodule
`default_nettype wire
